/* File: afs_map.vh */
// Purpose: Offsets, field positions, reset values and timing counts for the fault status bank
// Assumes: Byte-wide register port, 8-bit offsets
// Notes: Definitions only
`ifndef AFS_MAP_VH
`define AFS_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AFS_OFF_CHANNEL_FAULT_STATUS 8'h70
`define AFS_OFF_GLOBAL_A 8'h71
`define AFS_OFF_GLOBAL_B 8'h72
`define AFS_OFF_PIN_MASK 8'h74
`define AFS_OFF_MISC_CTRL 8'h76
`define AFS_OFF_FAULT_CLEAR 8'h78

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AFS_BIT_LEFT_DC 3
`define AFS_BIT_RIGHT_DC 2
`define AFS_BIT_LEFT_OC 1
`define AFS_BIT_RIGHT_OC 0
`define AFS_BIT_CRC_ERR 7
`define AFS_BIT_COEF_ERR 6
`define AFS_BIT_BOOT_ERR 5
`define AFS_BIT_CLK_FAULT 2
`define AFS_BIT_SUPPLY_OV 1
`define AFS_BIT_SUPPLY_UV 0
`define AFS_BIT_RIGHT_CYCLIM 2
`define AFS_BIT_LEFT_CYCLIM 1
`define AFS_BIT_THERMAL 0
`define AFS_BIT_CLEAR_CMD 7
`define AFS_BIT_DC_MASK 1
`define AFS_BIT_THERM_AREC 4

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define AFS_RST_STATUS 8'h00
`define AFS_RST_CTRL 8'h00
`define AFS_SYNC_STAGES 3

`endif

/* File: afs_sync.v */
// Purpose: Three-stage synchroniser with agreement filter for one fault level
// Assumes: Input is asynchronous to core_clk
// Notes: A change counts when stages two and three agree
`default_nettype none

module afs_sync
(
    input wire core_clk,
    input wire sys_rst,
    input wire async_in,
    output reg level_out
);

// ----------------------------------------
// Synchroniser chain
// ----------------------------------------
reg stage1_reg; // Only read by stage2
reg stage2_reg;
reg stage3_reg;

// Shift and filter; first stage feeds only the second
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        stage1_reg <= 1'b0;
        stage2_reg <= 1'b0;
        stage3_reg <= 1'b0;
        level_out <= 1'b0;
    end
    else
    begin
        stage1_reg <= async_in;
        stage2_reg <= stage1_reg;
        stage3_reg <= stage2_reg;
        // Agreement rejects a single-cycle metastable glitch
        if (stage2_reg == stage3_reg)
        begin
            level_out <= stage3_reg;
        end
    end
end

endmodule
`default_nettype wire

/* File: afs_rd_mux.v */
// Purpose: Registered read-data multiplexer for the fault register bank
// Assumes: Same clock as the bank
// Notes: Unmapped offsets read zero
`default_nettype none
`include "afs_map.vh"

module afs_rd_mux
(
    input wire core_clk,
    input wire sys_rst,
    input wire [7:0] rd_addr,
    input wire [7:0] chan_val,
    input wire [7:0] glob_a_val,
    input wire [7:0] glob_b_val,
    input wire [7:0] pin_mask_val,
    input wire [7:0] misc_val,
    output reg [7:0] rd_data
);

// ----------------------------------------
// Registered read selection
// ----------------------------------------
// Register gives read data one cycle after the address
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        rd_data <= 8'h00;
    end
    else
    begin
        case (rd_addr)
            `AFS_OFF_CHANNEL_FAULT_STATUS: rd_data <= chan_val;
            `AFS_OFF_GLOBAL_A: rd_data <= glob_a_val;
            `AFS_OFF_GLOBAL_B: rd_data <= glob_b_val;
            `AFS_OFF_PIN_MASK: rd_data <= pin_mask_val;
            `AFS_OFF_MISC_CTRL: rd_data <= misc_val;
            // Clear register is write-only, reads zero
            default: rd_data <= 8'h00;
        endcase
    end
end

endmodule
`default_nettype wire

/* File: afs_fault_bank.v */
// Purpose: Fault status register bank of a stereo class-D amplifier
// Assumes: Control port decoded to byte address and write strobe
// Notes: Fault sources arrive asynchronously and are synchronised here
`default_nettype none
`include "afs_map.vh"

// ----------------------------------------
// Timing overview
// ----------------------------------------
// A source edge reaches its status bit after four cycles of
// synchroniser and filter and one register stage; a live cause
// sets outputs_hiz in that same cycle, while the fault pin and
// outputs_hiz from latched bits follow one cycle later.

module afs_fault_bank
#(
    parameter NUM_SRC = 13 // Number of asynchronous fault sources
)
(
    input wire core_clk,
    input wire sys_rst,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    output wire [7:0] reg_rdata,
    // Fault sources, asynchronous active-high levels
    input wire left_dc_fault,
    input wire right_dc_fault,
    input wire left_overcurrent_fault,
    input wire right_overcurrent_fault,
    input wire clock_fault,
    input wire power_supply_overvoltage,
    input wire power_supply_undervoltage,
    input wire otp_crc_error,
    input wire filter_coef_write_error,
    input wire boot_load_error,
    input wire right_cycle_limit_fault,
    input wire left_cycle_limit_fault,
    input wire thermal_shutdown_fault,
    // Protection outputs, all registered
    output reg outputs_hiz,
    output reg fault_pin_out,
    output reg fault_pin_oe
);

// ----------------------------------------
// Source synchronisation
// ----------------------------------------
wire [NUM_SRC-1:0] src_async; // Raw fault levels
wire [NUM_SRC-1:0] src_sync; // Filtered fault levels

// Packing order matches the index map of the named views
assign src_async = {thermal_shutdown_fault, left_cycle_limit_fault,
    right_cycle_limit_fault, boot_load_error, filter_coef_write_error,
    otp_crc_error, power_supply_undervoltage, power_supply_overvoltage,
    clock_fault, right_overcurrent_fault, left_overcurrent_fault,
    right_dc_fault, left_dc_fault};

// One synchroniser per source
// Trade-off: a pulse under two cycles is filtered out, which
// suits slow analog fault levels but not single-cycle strobes
genvar gi;
generate
    for (gi = 0; gi < NUM_SRC; gi = gi + 1)
    begin : g_sync
        afs_sync u_sync
        (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .async_in(src_async[gi]),
            .level_out(src_sync[gi])
        );
    end
endgenerate

// Named views of the filtered sources
wire s_left_dc = src_sync[0];
wire s_right_dc = src_sync[1];
wire s_left_oc = src_sync[2];
wire s_right_oc = src_sync[3];

// Auto-recovering protection sources
wire s_clk = src_sync[4];
wire s_ov = src_sync[5];
wire s_uv = src_sync[6];

// Memory and load errors
wire s_crc = src_sync[7];
wire s_coef = src_sync[8];
wire s_boot = src_sync[9];

// Cycle-limit and thermal sources
wire s_rcbc = src_sync[10];
wire s_lcbc = src_sync[11];
wire s_therm = src_sync[12];

// ----------------------------------------
// Status and control registers
// ----------------------------------------
reg [7:0] chan_reg; // Channel fault status
reg [7:0] chan_next;
reg [7:0] glob_a_reg; // First global fault status
reg [7:0] glob_a_next;
reg [7:0] glob_b_reg; // Second global fault status
reg [7:0] glob_b_next;
reg [7:0] pin_mask_reg; // Pin report mask control
reg [7:0] misc_reg; // Miscellaneous control
reg therm_hold_reg; // Thermal shutdown held until clear
reg therm_hold_next;

// Write decode
wire wr_clear = reg_wr && (reg_addr == `AFS_OFF_FAULT_CLEAR)
    && reg_wdata[`AFS_BIT_CLEAR_CMD];
// Mask and misc registers take the whole byte
wire wr_mask = reg_wr && (reg_addr == `AFS_OFF_PIN_MASK);
wire wr_misc = reg_wr && (reg_addr == `AFS_OFF_MISC_CTRL);

// Status writes from the port are ignored: registers are read-only
wire dc_masked = pin_mask_reg[`AFS_BIT_DC_MASK];
wire therm_arec = misc_reg[`AFS_BIT_THERM_AREC];

// ----------------------------------------
// Sticky status next state
// ----------------------------------------
// Clear wipes latched bits; a live source re-sets it, so set wins
always @*
begin
    chan_next = chan_reg;
    glob_a_next = glob_a_reg;
    glob_b_next = glob_b_reg;
    therm_hold_next = therm_hold_reg;
    if (wr_clear)
    begin
        chan_next = `AFS_RST_STATUS;
        glob_a_next = `AFS_RST_STATUS;
        glob_b_next = `AFS_RST_STATUS;
        // A held thermal shutdown is released by the clear too
        therm_hold_next = 1'b0;
    end

    // Sets follow the clear, so a live or same-cycle event survives
    if (s_left_dc)
    begin
        chan_next[`AFS_BIT_LEFT_DC] = 1'b1;
    end

    // Right DC fault, same policy as the left
    if (s_right_dc)
    begin
        chan_next[`AFS_BIT_RIGHT_DC] = 1'b1;
    end

    // Left over-current latches, no self recovery
    if (s_left_oc)
    begin
        chan_next[`AFS_BIT_LEFT_OC] = 1'b1;
    end

    // Right over-current, same policy
    if (s_right_oc)
    begin
        chan_next[`AFS_BIT_RIGHT_OC] = 1'b1;
    end

    // Memory check failure is status only
    if (s_crc)
    begin
        glob_a_next[`AFS_BIT_CRC_ERR] = 1'b1;
    end

    // Coefficient write failure is status only
    if (s_coef)
    begin
        glob_a_next[`AFS_BIT_COEF_ERR] = 1'b1;
    end

    // Boot load failure; zero means the load succeeded
    if (s_boot)
    begin
        glob_a_next[`AFS_BIT_BOOT_ERR] = 1'b1;
    end

    // Clock fault keeps its bit while the stage recovers
    if (s_clk)
    begin
        glob_a_next[`AFS_BIT_CLK_FAULT] = 1'b1;
    end

    // Over-voltage latches its bit, recovery is live
    if (s_ov)
    begin
        glob_a_next[`AFS_BIT_SUPPLY_OV] = 1'b1;
    end

    // Under-voltage, same policy as over-voltage
    if (s_uv)
    begin
        glob_a_next[`AFS_BIT_SUPPLY_UV] = 1'b1;
    end

    // Cycle-limit faults are status only, no shutdown
    if (s_rcbc)
    begin
        glob_b_next[`AFS_BIT_RIGHT_CYCLIM] = 1'b1;
    end

    // Left cycle-limit fault
    if (s_lcbc)
    begin
        glob_b_next[`AFS_BIT_LEFT_CYCLIM] = 1'b1;
    end

    // Thermal shutdown latches its bit in every mode
    if (s_therm)
    begin
        glob_b_next[`AFS_BIT_THERMAL] = 1'b1;
        // Without auto recovery the shutdown persists until cleared
        therm_hold_next = ~therm_arec;
    end

    // Reserved positions forced to zero, whatever was set above
    chan_next[7:4] = 4'h0;
    glob_a_next[4:3] = 2'h0;
    glob_b_next[7:3] = 5'h00;
end

// Register update, all status zero after reset
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        // Status and thermal hold cleared together
        chan_reg <= `AFS_RST_STATUS;
        glob_a_reg <= `AFS_RST_STATUS;
        glob_b_reg <= `AFS_RST_STATUS;
        therm_hold_reg <= 1'b0;
    end
    else
    begin
        // Every register advances each cycle
        chan_reg <= chan_next;
        glob_a_reg <= glob_a_next;
        glob_b_reg <= glob_b_next;
        therm_hold_reg <= therm_hold_next;
    end
end

// ----------------------------------------
// Control registers
// ----------------------------------------
// Writable mask and misc registers steer pin and recovery
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        // Mask and recovery controls start disabled
        pin_mask_reg <= `AFS_RST_CTRL;
        misc_reg <= `AFS_RST_CTRL;
    end
    else
    begin
        // Only the DC mask bit acts; the rest reads back
        if (wr_mask)
        begin
            pin_mask_reg <= reg_wdata;
        end
        // Only the thermal recovery bit acts; the rest reads back
        if (wr_misc)
        begin
            misc_reg <= reg_wdata;
        end
    end
end

// ----------------------------------------
// Output stage protection and fault pin
// ----------------------------------------
// Hi-Z follows live auto-recovering faults; latched faults hold it
// Limitation: a DC or over-current fault keeps the stage off until cleared
wire latched_hiz = |chan_reg[3:0]; // DC and over-current need clear
wire live_hiz = s_clk | s_ov | s_uv | s_therm | therm_hold_reg;
wire dc_live = chan_reg[`AFS_BIT_LEFT_DC] | chan_reg[`AFS_BIT_RIGHT_DC];
wire oc_live = chan_reg[`AFS_BIT_LEFT_OC] | chan_reg[`AFS_BIT_RIGHT_OC];
// Memory, load and cycle-limit bits are status only, never reported
wire report = (dc_live & ~dc_masked)
    | oc_live
    | (glob_a_reg[2:0] != 3'h0)
    | glob_b_reg[`AFS_BIT_THERMAL];

// Registered so outputs come straight from flip-flops
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        // Quiet outputs while in reset
        outputs_hiz <= 1'b0;
        fault_pin_out <= 1'b0;
        fault_pin_oe <= 1'b0;
    end
    else
    begin
        // Power stage released only when no cause remains
        outputs_hiz <= latched_hiz | live_hiz;
        // Open-drain style: drive low while reporting, active low fault
        fault_pin_out <= 1'b0;
        fault_pin_oe <= report;
    end
end

// ----------------------------------------
// Read path
// ----------------------------------------
// Registered read data, valid one cycle after the address
afs_rd_mux u_rd_mux
(
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .rd_addr(reg_addr),
    .chan_val(chan_reg),
    .glob_a_val(glob_a_reg),
    .glob_b_val(glob_b_reg),
    .pin_mask_val(pin_mask_reg),
    .misc_val(misc_reg),
    .rd_data(reg_rdata)
);

endmodule
`default_nettype wire

/* File: afs_fault_bank_monitor.sv */
// Purpose: Port-level checks for the fault status bank
// Assumes: One clock, synchronous reset, bound to afs_fault_bank
// Notes: Windows allow for synchroniser and register lag
`default_nettype none
module afs_fault_bank_monitor
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic left_dc_fault,
    input wire logic right_dc_fault,
    input wire logic left_overcurrent_fault,
    input wire logic right_overcurrent_fault,
    input wire logic clock_fault,
    input wire logic power_supply_overvoltage,
    input wire logic power_supply_undervoltage,
    input wire logic thermal_shutdown_fault,
    input wire logic outputs_hiz,
    input wire logic fault_pin_out,
    input wire logic fault_pin_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // History of causes, so a rising output can be traced back
    // ----------------------------------------
    logic [9:0] prot_hist;
    logic [3:0] cmd_hist;
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            prot_hist <= 10'h000;
            cmd_hist <= 4'h0;
        end
        else
        begin
            prot_hist <= {prot_hist[8:0], left_dc_fault | right_dc_fault | left_overcurrent_fault
                | right_overcurrent_fault | clock_fault | power_supply_overvoltage
                | power_supply_undervoltage | thermal_shutdown_fault};
            cmd_hist <= {cmd_hist[2:0], reg_wr & ((reg_addr == 8'h78 & reg_wdata[7])
                | reg_addr == 8'h74)};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    AST_PIN_LOW: assert property (!fault_pin_out)
        else $error("fault pin drives high");
    AST_RST_QUIET: assert property (disable iff (1'b0) sys_rst |=>
        (!outputs_hiz && !fault_pin_oe && reg_rdata == 8'h00)) else $error("reset not quiet");
    AST_DC_HIZ: assert property (left_dc_fault [*6] |-> ##[0:4] outputs_hiz)
        else $error("dc fault without hiz");
    AST_OC_PIN: assert property (right_overcurrent_fault [*6] |-> ##[0:4] fault_pin_oe)
        else $error("oc fault not reported");
    AST_CLK_HIZ: assert property (clock_fault [*6] |-> ##[0:4] outputs_hiz)
        else $error("clock fault without hiz");
    AST_THERM_OUT: assert property (thermal_shutdown_fault [*6] |->
        ##[0:4] (outputs_hiz && fault_pin_oe)) else $error("thermal fault not acted on");
    AST_HIZ_CAUSE: assert property ($rose(outputs_hiz) |-> |prot_hist)
        else $error("hiz without cause");
    AST_PIN_HOLD: assert property ($fell(fault_pin_oe) |-> |cmd_hist)
        else $error("fault pin dropped without clear");
    AST_UNMAPPED_ZERO: assert property (reg_addr < 8'h70 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_CLEAR_RD_ZERO: assert property (reg_addr == 8'h78 |=> reg_rdata == 8'h00)
        else $error("clear register readable");
    cover property ($rose(outputs_hiz));
    cover property ($fell(fault_pin_oe));
    cover property (reg_wr && reg_addr == 8'h78);
endmodule
bind afs_fault_bank afs_fault_bank_monitor afs_fault_bank_monitor_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .left_dc_fault(left_dc_fault), .right_dc_fault(right_dc_fault),
    .left_overcurrent_fault(left_overcurrent_fault), .clock_fault(clock_fault),
    .right_overcurrent_fault(right_overcurrent_fault), .outputs_hiz(outputs_hiz),
    .power_supply_overvoltage(power_supply_overvoltage), .fault_pin_out(fault_pin_out),
    .power_supply_undervoltage(power_supply_undervoltage), .fault_pin_oe(fault_pin_oe),
    .thermal_shutdown_fault(thermal_shutdown_fault));
`default_nettype wire

/* File: afs_host_model.sv */
// Purpose: Host on the register port of the fault bank
// Assumes: Byte offsets, one-cycle write strobe
// Notes: Write data is scrambled once released
`default_nettype none
module afs_host_model
(
    input wire logic core_clk,
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata,
    output var logic reg_wr,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus at time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
    end
    // Write taken at the edge after the strobe rises
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // Data settles one cycle after the address edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        @(posedge core_clk);
        @(negedge core_clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the fault status bank
// Assumes: 40 MHz clock, host model on the register port
// Notes: Fixed seed keeps random source patterns repeatable
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [12:0] src = 13'h0000; // Sources in bit order of the map
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic reg_wr, outputs_hiz, fault_pin_out, fault_pin_oe;
    wire fault_line = fault_pin_oe ? fault_pin_out : 1'b1; // Pull-up on the pin
    int err_count = 0;
    int tests_run = 0;
    int seed = 32'h2901;
    always #12.5 core_clk = ~core_clk;
    afs_host_model afs_host_model_inst (.core_clk(core_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata));
    afs_fault_bank afs_fault_bank_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .left_dc_fault(src[0]), .right_dc_fault(src[1]), .left_overcurrent_fault(src[2]),
        .right_overcurrent_fault(src[3]), .clock_fault(src[4]),
        .power_supply_overvoltage(src[5]), .power_supply_undervoltage(src[6]),
        .otp_crc_error(src[7]), .filter_coef_write_error(src[8]), .boot_load_error(src[9]),
        .right_cycle_limit_fault(src[10]), .left_cycle_limit_fault(src[11]),
        .thermal_shutdown_fault(src[12]), .outputs_hiz(outputs_hiz),
        .fault_pin_out(fault_pin_out), .fault_pin_oe(fault_pin_oe));
    // ----------------------------------------
    // Expected status from a source pattern
    // ----------------------------------------
    function automatic logic [7:0] sa(int i);
        return i < 4 ? 8'h70 : i < 10 ? 8'h71 : 8'h72;
    endfunction
    function automatic logic [7:0] ev(logic [12:0] s, logic [7:0] a);
        int bp [13] = '{3, 2, 1, 0, 2, 1, 0, 7, 6, 5, 2, 1, 0};
        ev = 8'h00;
        for (int i = 0; i < 13; i++)
            if (s[i] && sa(i) == a)
                ev[bp[i]] = 1'b1;
    endfunction
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic rdchk(logic [7:0] a, logic [7:0] e);
        afs_host_model_inst.rd(a, rd);
        chk("rdata", e, rd);
    endtask
    task automatic setsrc(logic [12:0] s);
        @(posedge core_clk);
        src <= s;
    endtask
    task automatic step(int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic rst();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
    endtask
    // Bounded wait; a stuck output ends the run
    task automatic wait_hiz();
        int k;
        k = 0;
        while (outputs_hiz !== 1'b1 && k < 20)
        begin
            @(negedge core_clk);
            k++;
        end
        if (outputs_hiz !== 1'b1)
        begin
            chk("hiz wait", 8'h01, 8'h00);
            final_report();
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [12:0] r;
        rst();
        for (int a = 8'h70; a < 8'h73; a++)
            rdchk(a[7:0], 8'h00);
        rdchk(8'h40, 8'h00);
        rdchk(8'h78, 8'h00);
        $display("test reset done");
        // Each source alone: live, after removal, after clear
        for (int i = 0; i < 13; i++)
        begin
            setsrc(13'h0001 << i);
            step(8);
            chk("hiz live", {7'h00, i < 7 || i == 12}, {7'h00, outputs_hiz});
            setsrc(13'h0000);
            step(8);
            rdchk(sa(i), ev(13'h0001 << i, sa(i)));
            chk("hiz after", {7'h00, i < 4 || i == 12}, {7'h00, outputs_hiz});
            chk("line", {7'h00, !(i < 7 || i == 12)}, {7'h00, fault_line});
            afs_host_model_inst.wr(8'h78, 8'h80);
            rdchk(sa(i), 8'h00);
            chk("line clr", 8'h01, {7'h00, fault_line});
        end
        $display("test sources done");
        afs_host_model_inst.wr(8'h74, 8'h02);
        setsrc(13'h0001);
        wait_hiz();
        step(3);
        chk("masked", 8'h01, {7'h00, fault_line});
        afs_host_model_inst.wr(8'h74, 8'h00);
        step(3);
        chk("unmasked", 8'h00, {7'h00, fault_line});
        setsrc(13'h0000);
        step(8);
        afs_host_model_inst.wr(8'h78, 8'h80);
        afs_host_model_inst.wr(8'h76, 8'h10);
        setsrc(13'h1000);
        wait_hiz();
        setsrc(13'h0000);
        step(8);
        chk("thermal rec", 8'h00, {7'h00, outputs_hiz});
        rdchk(8'h72, 8'h01);
        setsrc(13'h0008);
        step(8);
        afs_host_model_inst.wr(8'h78, 8'h80);
        step(8);
        rdchk(8'h70, 8'h01);
        setsrc(13'h0000);
        step(8);
        afs_host_model_inst.wr(8'h78, 8'h80);
        $display("test mask recovery done");
        // Random patterns with writes to the read-only registers
        for (int n = 0; n < 12; n++)
        begin
            r = 13'($random(seed));
            for (int a = 8'h70; a < 8'h73; a++)
                afs_host_model_inst.wr(a[7:0], r[7:0]);
            setsrc(r);
            step(8);
            setsrc(13'h0000);
            step(8);
            for (int a = 8'h70; a < 8'h73; a++)
                rdchk(a[7:0], ev(r, a[7:0]));
            afs_host_model_inst.wr(8'h78, 8'h80);
        end
        $display("test random done");
        setsrc(13'h0080);
        step(8);
        setsrc(13'h0000);
        rst();
        rdchk(8'h71, 8'h00);
        $display("test second reset done");
        final_report();
    end
endmodule
`default_nettype wire
